// File: pkg/prg_pkg.sv
// shared constants and types for the physical random generator health gate
package prg_pkg;
  localparam int          OCT_W          = 8;
  localparam int          FIFO_DEPTH     = 4;
  // raw sample rate of the entropy source, one bit per period
  localparam int          CLK_MHZ        = 250;
  localparam int          RAW_PERIOD_NS  = 16;
  localparam int          RAW_DIV        = (RAW_PERIOD_NS * CLK_MHZ) / 1000;
  localparam logic [1:0]  DIV_MAX        = 2'(RAW_DIV - 1);
  // total failure: this many equal raw bits in a row
  localparam logic [5:0]  TF_RUN         = 6'h20;
  localparam int          DLY_LEN        = 32;
  localparam logic [5:0]  DLY_FULL       = 6'h20;
  // online test window and accepted count of ones in it
  localparam logic [7:0]  WIN_LAST       = 8'hff;
  localparam logic [8:0]  ONES_LO        = 9'h060;
  localparam logic [8:0]  ONES_HI        = 9'h0a0;
  localparam logic [2:0]  PERIOD_LAST    = 3'h7;
  localparam logic [3:0]  OCT_FULL       = 4'h8;

  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_RUN   = 2'b01,
    ST_FAIL  = 2'b10
  } prg_state_t;
endpackage

// File: pkg/prg_fifo_if.sv
// octet path between the health gate and its output fifo
`timescale 1ns/1ps
interface prg_fifo_if;
  import prg_pkg::*;
  logic             wr_valid;
  logic             wr_ready;
  logic [OCT_W-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [OCT_W-1:0] rd_data;
  logic             flush;

  modport fifo (input wr_valid, input wr_data, input rd_ready, input flush,
                output wr_ready, output rd_valid, output rd_data);
  modport user (output wr_valid, output wr_data, output rd_ready, output flush,
                input wr_ready, input rd_valid, input rd_data);
endinterface

// File: rtl/prg_fifo.sv
// small flop fifo with valid/ready on both sides and a synchronous flush
`timescale 1ns/1ps
module prg_fifo
  import prg_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // octet path
  prg_fifo_if.fifo f
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr;
    logic [AW-1:0]       rd;
    logic [AW:0]         cnt;
  } prg_fifo_st_t;

  prg_fifo_st_t r;
  prg_fifo_st_t next_r;
  logic         do_wr;
  logic         do_rd;

  assign f.wr_ready = (r.cnt != (AW + 1)'(D));
  assign f.rd_valid = (r.cnt != '0);
  assign f.rd_data  = r.mem[r.rd];

  always_comb begin
    next_r = r;
    do_wr  = f.wr_valid && f.wr_ready;
    do_rd  = f.rd_valid && f.rd_ready;
    if (do_wr) begin
      next_r.mem[r.wr] = f.wr_data;
      next_r.wr        = (r.wr == AW'(D - 1)) ? '0 : r.wr + 1'b1;
    end
    if (do_rd) begin
      next_r.rd = (r.rd == AW'(D - 1)) ? '0 : r.rd + 1'b1;
    end
    next_r.cnt = r.cnt + (AW + 1)'(do_wr) - (AW + 1)'(do_rd);
    // flush drops everything held, including a same-cycle write
    if (f.flush) begin
      next_r.wr  = '0;
      next_r.rd  = '0;
      next_r.cnt = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// File: rtl/prg_health_gate.sv
// physical random generator with total failure and online health gating
//
// Contract
// - total failure check runs right at start
// - after total failure, no output at all
// - drop output built from post-failure raw bits
// - online test at start-up and during operation
// - no output before start-up pass or after defect
// - online test periodic or continuous, bounded latency
// - both schedules offered, software picks one
// - output delivered as whole octets
// - output entropy above 0.997 per bit
// - software starts self-test, reads pass/fail flag
`timescale 1ns/1ps
module prg_health_gate
  import prg_pkg::*;
(
  // clock and reset
  input  wire logic             MCLK,
  input  wire logic             SYS_RST,
  // raw entropy source, asynchronous
  input  wire logic             RAW_BIT,
  // software control
  input  wire logic             SELFTEST_START,
  input  wire logic             MODE_CONTINUOUS,
  // software status
  output logic                  SELFTEST_DONE,
  output logic                  SELFTEST_PASS,
  output logic                  TOTAL_FAIL,
  output logic                  STAT_DEFECT,
  output logic                  BLOCKED,
  // octet output stream
  output logic                  OUT_VALID,
  output logic [OCT_W-1:0]      OUT_DATA,
  input  wire logic             OUT_READY
);
  typedef struct packed {
    logic                sync1;
    logic                sync2;
    logic [1:0]          div;
    logic                last_bit;
    logic [5:0]          run_len;
    logic [DLY_LEN-1:0]  dly;
    logic [5:0]          dly_cnt;
    logic [OCT_W-1:0]    oct;
    logic [3:0]          oct_cnt;
    logic [7:0]          win_cnt;
    logic [8:0]          ones;
    logic [2:0]          per_cnt;
    prg_state_t          state;
    logic                done;
    logic                pass;
    logic                tfail;
    logic                defect;
  } prg_gate_st_t;

  prg_gate_st_t r;
  prg_gate_st_t next_r;
  prg_fifo_if   fq ();

  logic             tick;
  logic             raw;
  logic [5:0]       run_new;
  logic             tf_hit;
  logic             release_bit;
  logic [8:0]       ones_total;
  logic             win_end;
  logic             testing;
  logic             win_bad;
  logic             flush;
  logic             oct_push;

  function automatic logic ones_out_of_range(input logic [8:0] n);
    return (n < ONES_LO) || (n > ONES_HI);
  endfunction

  // octets enter the fifo only while the gate is open
  assign oct_push    = (r.oct_cnt == OCT_FULL) && (r.state == ST_RUN);
  assign fq.wr_valid = oct_push;
  assign fq.wr_data  = r.oct;
  assign fq.rd_ready = OUT_READY && (r.state == ST_RUN);
  assign fq.flush    = flush;

  always_comb begin
    next_r      = r;
    flush       = 1'b0;
    raw         = r.sync2;
    tick        = (r.div == DIV_MAX);
    run_new     = r.run_len;
    tf_hit      = 1'b0;
    release_bit = 1'b0;
    ones_total  = r.ones + 9'(raw);
    win_end     = tick && (r.win_cnt == WIN_LAST);
    win_bad     = 1'b0;
    // start-up window is always tested, later ones by schedule
    testing     = (r.state == ST_START) || MODE_CONTINUOUS || (r.per_cnt == '0);

    // raw bit passes two flops before anything reads it
    next_r.sync1 = RAW_BIT;
    next_r.sync2 = r.sync1;
    next_r.div   = tick ? 2'h0 : r.div + 2'h1;

    if (tick) begin
      // run of equal bits is the total failure detector, active from the start
      if ((raw == r.last_bit) && (r.run_len != '0)) begin
        run_new = (r.run_len == TF_RUN) ? TF_RUN : r.run_len + 6'h01;
      end else begin
        run_new = 6'h01;
      end
      next_r.run_len  = run_new;
      next_r.last_bit = raw;
      tf_hit          = (run_new == TF_RUN);

      // bits wait in the delay line until a whole detection span has passed,
      // so no released bit can belong to a total failure not yet flagged
      next_r.dly = {r.dly[DLY_LEN-2:0], raw};
      if (r.dly_cnt == DLY_FULL) begin
        release_bit = 1'b1;
      end else begin
        next_r.dly_cnt = r.dly_cnt + 6'h01;
      end

      // octet assembly stalls while the fifo is full; bits are discarded
      if (release_bit && (r.oct_cnt != OCT_FULL)) begin
        next_r.oct     = {r.oct[OCT_W-2:0], r.dly[DLY_LEN-1]};
        next_r.oct_cnt = r.oct_cnt + 4'h1;
      end

      // online test: count of ones per window of raw bits
      next_r.win_cnt = r.win_cnt + 8'h01;
      next_r.ones    = ones_total;
      if (win_end) begin
        next_r.ones    = 9'h000;
        next_r.per_cnt = (r.per_cnt == PERIOD_LAST) ? 3'h0 : r.per_cnt + 3'h1;
        win_bad        = testing && ones_out_of_range(ones_total);
      end
    end

    // an octet leaves the assembler once the fifo takes it
    if (oct_push && fq.wr_ready) begin
      next_r.oct_cnt = (tick && release_bit) ? 4'h1 : 4'h0;
      next_r.oct     = (tick && release_bit) ? {{(OCT_W-1){1'b0}}, r.dly[DLY_LEN-1]} : r.oct;
    end

    unique case (r.state)
      ST_START: begin
        if (tf_hit) begin
          next_r.tfail = 1'b1;
          next_r.done  = 1'b1;
          next_r.state = ST_FAIL;
        end else if (win_bad) begin
          next_r.defect = 1'b1;
          next_r.done   = 1'b1;
          next_r.state  = ST_FAIL;
        end else if (win_end) begin
          next_r.pass  = 1'b1;
          next_r.done  = 1'b1;
          next_r.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (tf_hit) begin
          next_r.tfail = 1'b1;
          next_r.pass  = 1'b0;
          next_r.state = ST_FAIL;
        end else if (win_bad) begin
          next_r.defect = 1'b1;
          next_r.pass   = 1'b0;
          next_r.state  = ST_FAIL;
        end
      end
      ST_FAIL: begin
        // stays shut until a reset or a software self-test request restarts the start-up tests
        next_r.state = ST_FAIL;
      end
      default: begin
        next_r.state = ST_FAIL;
      end
    endcase

    // any failure discards every bit still in flight
    if ((r.state != ST_FAIL) && (tf_hit || win_bad)) begin
      flush          = 1'b1;
      next_r.dly_cnt = 6'h00;
      next_r.oct_cnt = 4'h0;
    end

    // software self-test request restarts the start-up tests
    if (SELFTEST_START) begin
      flush          = 1'b1;
      next_r.state   = ST_START;
      next_r.done    = 1'b0;
      next_r.pass    = 1'b0;
      next_r.tfail   = 1'b0;
      next_r.defect  = 1'b0;
      next_r.run_len = 6'h00;
      next_r.dly_cnt = 6'h00;
      next_r.oct_cnt = 4'h0;
      next_r.win_cnt = 8'h00;
      next_r.ones    = 9'h000;
      next_r.per_cnt = 3'h0;
      next_r.div     = 2'h0;
    end
  end

  // reset leaves the gate closed and the start-up tests pending
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  prg_fifo #(
    .W (OCT_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk (MCLK),
    .rst (SYS_RST),
    .f   (fq)
  );

  // the entropy figure rests on the source; the gate holds octets back for the total failure span
  // only, so bits of a window that the online test later fails can already be out
  assign OUT_VALID     = fq.rd_valid && (r.state == ST_RUN);
  assign OUT_DATA      = fq.rd_data;
  assign SELFTEST_DONE = r.done;
  assign SELFTEST_PASS = r.pass;
  assign TOTAL_FAIL    = r.tfail;
  assign STAT_DEFECT   = r.defect;
  assign BLOCKED       = (r.state != ST_RUN);
endmodule

// File: bench/prg_health_gate_monitor.sv
// port-level checks of the health gate
`timescale 1ns/1ps
module prg_health_gate_monitor
  import prg_pkg::*;
(
  // clock, reset and inputs
  input wire logic             MCLK,
  input wire logic             SYS_RST,
  input wire logic             RAW_BIT,
  input wire logic             SELFTEST_START,
  input wire logic             MODE_CONTINUOUS,
  input wire logic             OUT_READY,
  // status and stream
  input wire logic             SELFTEST_DONE,
  input wire logic             SELFTEST_PASS,
  input wire logic             TOTAL_FAIL,
  input wire logic             STAT_DEFECT,
  input wire logic             BLOCKED,
  input wire logic             OUT_VALID,
  input wire logic [OCT_W-1:0] OUT_DATA
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  property p_rst; $fell(SYS_RST) |-> BLOCKED && !SELFTEST_PASS && !OUT_VALID; endproperty
  a_rst: assert property (p_rst) else $error("not blocked after reset");
  property p_tf; TOTAL_FAIL |-> !OUT_VALID; endproperty
  a_tf: assert property (p_tf) else $error("output after total failure");
  property p_def; STAT_DEFECT |-> !OUT_VALID; endproperty
  a_def: assert property (p_def) else $error("output after defect");
  property p_vld; OUT_VALID |-> SELFTEST_PASS && !BLOCKED; endproperty
  a_vld: assert property (p_vld) else $error("valid while blocked");
  property p_start; SELFTEST_START |=> !SELFTEST_DONE && !TOTAL_FAIL && !STAT_DEFECT && BLOCKED; endproperty
  a_start: assert property (p_start) else $error("start did not clear status");
  property p_sticky; TOTAL_FAIL && !SELFTEST_START |=> TOTAL_FAIL; endproperty
  a_sticky: assert property (p_sticky) else $error("total failure flag dropped");
  property p_first; $rose(TOTAL_FAIL) |-> SELFTEST_DONE && !SELFTEST_PASS; endproperty
  a_first: assert property (p_first) else $error("failure without done");
  // one start-up window plus slack; a counter stands in for a long delay range
  localparam logic [10:0] DONE_LIM = 11'h44c;
  logic [10:0]            wait_cnt;
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wait_cnt <= 11'h000;
    end else if (SELFTEST_START || SELFTEST_DONE) begin
      wait_cnt <= 11'h000;
    end else if (wait_cnt != 11'h7ff) begin
      wait_cnt <= wait_cnt + 11'h001;
    end
  end
  property p_bound; wait_cnt <= DONE_LIM; endproperty
  a_bound: assert property (p_bound) else $error("start-up test too slow");
  property p_hold; OUT_VALID && !OUT_READY |=> BLOCKED || OUT_VALID && $stable(OUT_DATA); endproperty
  a_hold: assert property (p_hold) else $error("octet lost while stalled");
endmodule
bind prg_health_gate prg_health_gate_monitor u_mon (.MCLK, .SYS_RST, .RAW_BIT, .SELFTEST_START,
  .MODE_CONTINUOUS, .OUT_READY, .SELFTEST_DONE, .SELFTEST_PASS, .TOTAL_FAIL, .STAT_DEFECT,
  .BLOCKED, .OUT_VALID, .OUT_DATA);

// File: bench/prg_src_model.sv
// entropy source stand-in: random, stuck or one-in-four biased bits
`timescale 1ns/1ps
module prg_src_model
  import prg_pkg::*;
(
  // clock and control
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [1:0] mode,
  input wire logic       rnd,
  // raw bit
  output logic           raw
);
  logic [1:0] div;
  logic [1:0] ph;
  // one new level per raw period so every sample sees a settled bit
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= 2'h0;
      ph  <= 2'h0;
      raw <= 1'b0;
    end else begin
      div <= div + 2'h1;
      if (div == DIV_MAX) begin
        ph <= ph + 2'h1;
        case (mode)
          2'h1: raw <= 1'b0;
          2'h2: raw <= (ph == 2'h0);
          default: raw <= rnd;
        endcase
      end
    end
  end
endmodule

// File: bench/test_prg_health_gate.sv
// self-checking bench for the health gate
`timescale 1ns/1ps
module test_prg_health_gate
  import prg_pkg::*;
;
  logic             MCLK = 1'b0;
  logic             SYS_RST = 1'b1;
  logic             SELFTEST_START = 1'b0;
  logic             MODE_CONTINUOUS = 1'b0;
  logic             OUT_READY = 1'b0;
  logic             RAW_BIT;
  logic             SELFTEST_DONE, SELFTEST_PASS, TOTAL_FAIL, STAT_DEFECT, BLOCKED, OUT_VALID;
  logic [OCT_W-1:0] OUT_DATA;
  logic [1:0]       src_mode = 2'h0;
  logic             rnd = 1'b0;
  logic             stall = 1'b0;
  int               failures = 0;
  int               checks = 0;
  int               octs = 0;
  int               o0 = 0;
  int               ones_seen = 0;
  int               p0 = 0;
  int               cyc = 0;
  int               seed = 32'h495d_f44d;

  always #2 MCLK = ~MCLK;

  prg_health_gate DUT (.MCLK, .SYS_RST, .RAW_BIT, .SELFTEST_START, .MODE_CONTINUOUS,
    .SELFTEST_DONE, .SELFTEST_PASS, .TOTAL_FAIL, .STAT_DEFECT, .BLOCKED, .OUT_VALID,
    .OUT_DATA, .OUT_READY);
  prg_src_model u_src (.clk(MCLK), .rst(SYS_RST), .mode(src_mode), .rnd(rnd), .raw(RAW_BIT));

  task automatic report_and_stop;
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // a random reader, ready on about half the cycles, keeps the fifo near empty unless stall holds it off
  always @(posedge MCLK) begin
    rnd <= 1'($random(seed));
    OUT_READY <= stall ? 1'b0 : 1'($random(seed));
    if (OUT_VALID === 1'b1 && OUT_READY === 1'b1) begin
      octs      <= octs + 1;
      ones_seen <= ones_seen + $countones(OUT_DATA);
    end
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t flag %b want %b", $time, got, exp);
    end
  endtask

  task automatic cmpn(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("[FAIL] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // one octet per eight raw samples once the backlog is gone
  function automatic int oct_expect(input int cycles);
    return cycles / (RAW_DIV * OCT_W);
  endfunction

  // a fair source gives half of the delivered bits set
  function automatic int ones_mid(input int n);
    return n * OCT_W / 2;
  endfunction

  // bounded wait on done, or on either failure flag
  task automatic wait_for(input logic fault, input int lim);
    int n;
    n = 0;
    while ((fault ? (TOTAL_FAIL | STAT_DEFECT) : SELFTEST_DONE) !== 1'b1 && n < lim) begin
      @(negedge MCLK);
      n++;
    end
  endtask

  task automatic restart(input logic [1:0] m, input logic cont);
    @(posedge MCLK);
    src_mode <= m;
    MODE_CONTINUOUS <= cont;
    SELFTEST_START <= 1'b1;
    @(posedge MCLK);
    SELFTEST_START <= 1'b0;
    // let the cleared status settle before anyone looks at it
    @(negedge MCLK);
  endtask

  initial begin
    repeat (2) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(negedge MCLK);
    cmp1(BLOCKED, 1'b1);
    cmp1(SELFTEST_PASS, 1'b0);
    wait_for(1'b0, 1100);
    cmp1(SELFTEST_DONE, 1'b1);
    cmp1(SELFTEST_PASS, 1'b1);
    cmp1(TOTAL_FAIL, 1'b0);
    stall = 1'b1;
    repeat (300) @(negedge MCLK);
    cmp1(OUT_VALID, 1'b1);
    stall = 1'b0;
    o0 = octs;
    p0 = ones_seen;
    repeat (600) @(negedge MCLK);
    cmpn(octs - o0, oct_expect(600), oct_expect(600) + FIFO_DEPTH + 3);
    cmpn(ones_seen - p0, ones_mid(octs - o0) - 28, ones_mid(octs - o0) + 28);
    @(posedge MCLK);
    src_mode <= 2'h1;
    wait_for(1'b1, 200);
    cmp1(TOTAL_FAIL, 1'b1);
    o0 = octs;
    repeat (200) @(negedge MCLK);
    cmpn(octs - o0, 0, 0);
    restart(2'h1, 1'b0);
    wait_for(1'b0, 1100);
    cmp1(SELFTEST_DONE, 1'b1);
    cmp1(TOTAL_FAIL, 1'b1);
    cmp1(SELFTEST_PASS, 1'b0);
    restart(2'h2, 1'b1);
    wait_for(1'b0, 1100);
    cmp1(STAT_DEFECT, 1'b1);
    cmp1(SELFTEST_PASS, 1'b0);
    // periodic mode may wait out seven untested windows
    for (int c = 1; c >= 0; c--) begin
      restart(2'h0, 1'(c));
      wait_for(1'b0, 1100);
      cmp1(SELFTEST_PASS, 1'b1);
      @(posedge MCLK);
      src_mode <= 2'h2;
      wait_for(1'b1, c ? 2200 : 9300);
      cmp1(STAT_DEFECT, 1'b1);
      cmp1(OUT_VALID, 1'b0);
    end
    // a reset after a defect must close the gate and clear the sticky defect flag
    @(posedge MCLK);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(negedge MCLK);
    cmp1(STAT_DEFECT, 1'b0);
    cmp1(BLOCKED, 1'b1);
    report_and_stop();
  end
endmodule
